// *** hw/rsf_filters.sv ***
// torque command resonance suppression: manual notch, adaptive notch, low-pass
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module rsf_filters
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // resonance estimate from the speed loop analyser
  input wire logic res_valid_i,
  input wire logic [CODE_W-1:0] res_code_i,
  input wire logic [LVL_W-1:0] res_level_i,
  // torque command in
  input wire logic cmd_valid_i,
  input wire logic signed [15:0] cmd_data_i,
  // filtered torque command out
  output logic trq_valid_o,
  output logic signed [15:0] trq_data_o
);

  // software-visible settings
  logic [CODE_W-1:0] man_code;
  logic [DEPTH_W-1:0] man_depth;
  logic [15:0] filt_sel;
  logic [15:0] speed_gain2;
  logic [15:0] inertia_ratio;

  // adaptive notch state
  logic [CODE_W-1:0] adapt_code;
  logic [DEPTH_W-1:0] adapt_depth;
  rsf_adapt_type adapt_mode;
  logic large_sens;
  logic lpf_on;
  logic [LVL_W-1:0] threshold;
  logic in_band;
  logic [DEPTH_W-1:0] level_depth;
  logic [CODE_W-1:0] adapt_eff_code;

  // low-pass state
  logic [31:0] lpf_alpha;
  logic [31:0] next_alpha;
  logic [31:0] alpha_num;
  logic [31:0] alpha_den;
  logic signed [31:0] lpf_acc;
  logic signed [31:0] lpf_err;
  logic signed [49:0] lpf_step;

  // stage wiring
  logic s1_valid;
  logic signed [15:0] s1_data;
  logic s2_valid;
  logic signed [15:0] s2_data;

  // register writes; one shared selection word
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      man_code <= CODE_OFF;
      man_depth <= '0;
      filt_sel <= FILT_SEL_RESET; // R8 R10
      speed_gain2 <= SPEED_GAIN2_RESET;
      inertia_ratio <= INERTIA_RESET;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        NOTCH_CFG_ADDR: begin
          man_code <= reg_wdata_i[CODE_LSB +: CODE_W]; // R2
          man_depth <= reg_wdata_i[DEPTH_LSB +: DEPTH_W]; // R3
        end
        FILT_SEL_ADDR: filt_sel <= reg_wdata_i[15:0]; // R12
        SPEED_GAIN2_ADDR: speed_gain2 <= reg_wdata_i[15:0];
        INERTIA_RATIO_ADDR: inertia_ratio <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // decode the shared selection digits; unknown mode digits read as invalid
  always_comb begin
    unique case (filt_sel[MODE_DIG_LSB +: DIG_W])
      4'h1: adapt_mode = RSF_ADAPT_VALID; // R13
      4'h2: adapt_mode = RSF_ADAPT_HELD; // R13
      default: adapt_mode = RSF_ADAPT_INVALID;
    endcase
    large_sens = filt_sel[SENS_DIG_LSB +: DIG_W] == SENS_LARGE; // R13
    lpf_on = filt_sel[LPF_DIG_LSB +: DIG_W] != LPF_INVALID; // R10 R13
  end

  // detection decision for one estimate
  always_comb begin
    threshold = large_sens ? THR_LARGE : THR_NORMAL; // R9
    in_band = (res_code_i >= ADAPT_CODE_HI_FREQ) && (res_code_i <= ADAPT_CODE_LO_FREQ); // R6
    if (res_level_i >= LVL_DEEP) begin
      level_depth = 2'd0; // strong resonance earns a deep notch
    end else if (res_level_i >= LVL_MID) begin
      level_depth = 2'd1;
    end else begin
      level_depth = 2'd2;
    end
  end

  // adaptive tuning: follows the estimate while valid, frozen while held
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      adapt_code <= CODE_OFF;
      adapt_depth <= '0;
    end else if (adapt_mode == RSF_ADAPT_INVALID) begin
      adapt_code <= CODE_OFF;
      adapt_depth <= '0;
    end else if (adapt_mode == RSF_ADAPT_VALID && res_valid_i && in_band
                 && res_level_i >= threshold) begin
      adapt_code <= res_code_i; // R4 R5
      adapt_depth <= level_depth; // R4
    end
    // held mode leaves both untouched: R7
  end

  // while the adaptive mode is invalid the adaptive notch is off, so only the manual one acts
  assign adapt_eff_code = (adapt_mode == RSF_ADAPT_INVALID) ? CODE_OFF : adapt_code; // R6

  // cutoff tracking; the divide is slow logic but settings change rarely
  always_comb begin
    alpha_num = LPF_K * 32'(speed_gain2);
    alpha_den = 32'(inertia_ratio) + 32'(LPF_RATIO_DIV);
    next_alpha = alpha_num / alpha_den; // R11
    if (next_alpha > ALPHA_ONE) begin
      next_alpha = ALPHA_ONE; // keep the one-pole stable
    end
  end

  // registered cutoff coefficient, recomputed every cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      lpf_alpha <= '0;
    end else begin
      lpf_alpha <= next_alpha; // R11
    end
  end

  // manual notch first
  rsf_notch u_manual_notch (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .code_i(man_code),
    .depth_i(man_depth),
    .in_valid_i(cmd_valid_i),
    .in_data_i(cmd_data_i),
    .out_valid_o(s1_valid),
    .out_data_o(s1_data)
  ); // R14

  // adaptive notch second
  rsf_notch u_adapt_notch (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .code_i(adapt_eff_code),
    .depth_i(adapt_depth),
    .in_valid_i(s1_valid),
    .in_data_i(s1_data),
    .out_valid_o(s2_valid),
    .out_data_o(s2_data)
  ); // R14

  // one-pole low-pass, accumulator has eight fraction bits
  always_comb begin
    lpf_err = (32'(s2_data) <<< 8) - lpf_acc;
    lpf_step = $signed({1'b0, lpf_alpha[16:0]}) * lpf_err;
  end

  // low-pass state; bypassed and flushed when switched invalid
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !lpf_on) begin
      lpf_acc <= '0; // R10
    end else if (s2_valid) begin
      lpf_acc <= lpf_acc + lpf_step[47:16];
    end
  end

  // output stage, last of the series chain
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      trq_valid_o <= 1'b0;
      trq_data_o <= '0;
    end else begin
      trq_valid_o <= s2_valid; // R14
      if (s2_valid) begin
        // signed cast keeps negative samples from saturating high
        trq_data_o <= lpf_on ? sat16($signed(lpf_acc + lpf_step[47:16]) >>> 8) : s2_data; // R10
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      unique case (reg_addr_i)
        NOTCH_CFG_ADDR: begin
          reg_rdata_o[CODE_LSB +: CODE_W] <= man_code;
          reg_rdata_o[DEPTH_LSB +: DEPTH_W] <= man_depth;
        end
        FILT_SEL_ADDR: reg_rdata_o[15:0] <= filt_sel;
        SPEED_GAIN2_ADDR: reg_rdata_o[15:0] <= speed_gain2;
        INERTIA_RATIO_ADDR: reg_rdata_o[15:0] <= inertia_ratio;
        ADAPT_STATUS_ADDR: begin
          reg_rdata_o[CODE_LSB +: CODE_W] <= adapt_code;
          reg_rdata_o[DEPTH_LSB +: DEPTH_W] <= adapt_depth;
          reg_rdata_o[STAT_ACTIVE_BIT] <= adapt_eff_code != CODE_OFF;
          reg_rdata_o[STAT_HELD_BIT] <= adapt_mode == RSF_ADAPT_HELD;
        end
        LPF_ALPHA_ADDR: reg_rdata_o <= lpf_alpha;
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : rsf_filters

// *** hw/rsf_pkg.sv ***
// constants, register map and helpers for the resonance suppression filters
//
// Functional notes
// R1: notch filter attenuates one selectable frequency
// R2: code 01..1F picks frequency, 00 disables
// R3: two-bit depth: -40, -14, -8, -4 dB
// R4: valid adaptive mode tunes notch automatically
// R5: adaptive notch retunes when resonance moves
// R6: adaptive acts only on 150..500 Hz resonances
// R7: held mode freezes adaptive notch characteristics
// R8: shared selection resets to 0000, adaptive invalid
// R9: large sensitivity detects smaller resonances
// R10: low-pass valid by default, can be disabled
// R11: cutoff = gain2*10 / (2pi*(1+ratio*0.1))
// R12: one shared register selects low-pass and adaptive
// R13: shared register digits: lpf, mode, sensitivity
// R14: manual notch, adaptive notch, low-pass in series
package rsf_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] NOTCH_CFG_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] FILT_SEL_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] SPEED_GAIN2_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] INERTIA_RATIO_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] ADAPT_STATUS_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] LPF_ALPHA_ADDR = 8'h14;

  // notch configuration fields
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 5;
  localparam int DEPTH_LSB = 8;
  localparam int DEPTH_W = 2;
  localparam logic [CODE_W-1:0] CODE_OFF = 5'h00;

  // shared selection digits, one hex digit each
  localparam int LPF_DIG_LSB = 4;
  localparam int MODE_DIG_LSB = 8;
  localparam int SENS_DIG_LSB = 12;
  localparam int DIG_W = 4;
  localparam logic [15:0] FILT_SEL_RESET = 16'h0000;
  localparam logic [DIG_W-1:0] LPF_INVALID = 4'h1;
  localparam logic [DIG_W-1:0] SENS_LARGE = 4'h1;

  // status bit positions
  localparam int STAT_ACTIVE_BIT = 16;
  localparam int STAT_HELD_BIT = 17;

  // default gain settings
  localparam logic [15:0] SPEED_GAIN2_RESET = 16'h0320;
  localparam logic [15:0] INERTIA_RESET = 16'h0046;

  // adaptive modes
  typedef enum logic [1:0] {
    RSF_ADAPT_INVALID = 2'b00,
    RSF_ADAPT_VALID = 2'b01,
    RSF_ADAPT_HELD = 2'b10
  } rsf_adapt_type;

  // adaptive band: code 09 is 500 Hz, code 1E is 150 Hz
  localparam logic [CODE_W-1:0] ADAPT_CODE_HI_FREQ = 5'h09;
  localparam logic [CODE_W-1:0] ADAPT_CODE_LO_FREQ = 5'h1E;

  // detection thresholds and depth steps on the estimator level
  localparam int LVL_W = 16;
  localparam logic [LVL_W-1:0] THR_NORMAL = 16'h0400;
  localparam logic [LVL_W-1:0] THR_LARGE = 16'h0100;
  localparam logic [LVL_W-1:0] LVL_DEEP = 16'h4000;
  localparam logic [LVL_W-1:0] LVL_MID = 16'h1000;

  // sample timing: table frequency is 4500 Hz divided by the code
  localparam longint SAMPLE_HZ = 40000;
  localparam longint NOTCH_TOP_HZ = 4500;
  localparam longint TWO_PI_E4 = 62832;
  localparam int Q16 = 16;
  localparam longint NOTCH_F_BASE =
      (TWO_PI_E4 * NOTCH_TOP_HZ * (64'd1 << Q16)) / (64'd10000 * SAMPLE_HZ);
  // low-pass: alpha = 2pi*fc/fs = gain2*100 / (fs*(10+ratio))
  localparam longint LPF_GAIN_MUL = 10;
  localparam longint LPF_RATIO_DIV = 10;
  localparam logic [31:0] LPF_K = 32'((LPF_GAIN_MUL * LPF_RATIO_DIV * (64'd1 << Q16)) / SAMPLE_HZ);
  localparam logic [31:0] ALPHA_ONE = 32'h0001_0000;

  // notch depth factors d = 1 - 10^(dB/20), Q16
  localparam logic [16:0] DEPTH_K0 = 17'h0_FD71;
  localparam logic [16:0] DEPTH_K1 = 17'h0_CD6B;
  localparam logic [16:0] DEPTH_K2 = 17'h0_9A47;
  localparam logic [16:0] DEPTH_K3 = 17'h0_5EDE;

  // centre-frequency coefficient for a table code
  function automatic logic [17:0] notch_coef(input logic [CODE_W-1:0] code);
    if (code == CODE_OFF) begin
      return 18'h0_0000;
    end
    return 18'(NOTCH_F_BASE / longint'(code));
  endfunction : notch_coef

  // attenuation factor for a depth code
  function automatic logic [16:0] depth_k(input logic [DEPTH_W-1:0] d);
    unique case (d)
      2'd0: return DEPTH_K0;
      2'd1: return DEPTH_K1;
      2'd2: return DEPTH_K2;
      2'd3: return DEPTH_K3;
    endcase
  endfunction : depth_k

  // clamp a wide sample to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh0000_7FFF) begin
      return 16'sh7FFF;
    end
    if (v < -32'sh0000_8000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction : sat16

endpackage : rsf_pkg

// *** hw/rsf_notch.sv ***
// one state-variable notch stage with coded frequency and depth
`timescale 1ns/100ps
module rsf_notch
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // setting
  input wire logic [CODE_W-1:0] code_i,
  input wire logic [DEPTH_W-1:0] depth_i,
  // sample in
  input wire logic in_valid_i,
  input wire logic signed [15:0] in_data_i,
  // sample out
  output logic out_valid_o,
  output logic signed [15:0] out_data_o
);

  logic signed [31:0] lp;
  logic signed [31:0] bp;
  logic signed [31:0] x;
  logic signed [31:0] hp;
  logic signed [31:0] next_lp;
  logic signed [31:0] next_bp;
  logic signed [31:0] y;
  logic signed [18:0] f;
  logic signed [17:0] k;
  logic signed [50:0] prod_hp;
  logic signed [50:0] prod_bp;
  logic signed [49:0] prod_k;

  // states carry eight fraction bits; damping fixed at 1/2
  always_comb begin
    f = $signed({1'b0, notch_coef(code_i)});
    k = $signed({1'b0, depth_k(depth_i)});
    x = 32'(in_data_i) <<< 8;
    hp = x - lp - (bp >>> 1);
    prod_hp = f * hp;
    prod_bp = f * bp;
    next_bp = bp + prod_hp[47:16];
    next_lp = lp + prod_bp[47:16];
    prod_k = k * (bp >>> 1); // band-pass peaks at 2x, so half is unity
    // a bare part-select is unsigned and would turn the shift logical
    y = (x - $signed(prod_k[47:16])) >>> 8; // R1 R3
  end

  // filter state; code 00 bypasses and flushes state
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || code_i == CODE_OFF) begin
      lp <= '0; // R2
      bp <= '0;
    end else if (in_valid_i) begin
      lp <= next_lp;
      bp <= next_bp;
    end
  end

  // registered output, one cycle per stage
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        out_data_o <= (code_i == CODE_OFF) ? in_data_i : sat16(y); // R2
      end
    end
  end

endmodule : rsf_notch

// *** sim/rsf_filters_props.sv ***
// assertion checker for the resonance suppression filters
`timescale 1ns/100ps
module rsf_filters_props
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // resonance estimate
  input wire logic res_valid_i,
  input wire logic [CODE_W-1:0] res_code_i,
  input wire logic [LVL_W-1:0] res_level_i,
  // samples
  input wire logic cmd_valid_i,
  input wire logic signed [15:0] cmd_data_i,
  input wire logic trq_valid_o,
  input wire logic signed [15:0] trq_data_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [9:0] notch;
  logic [15:0] sel;
  logic pass;
  // shadow of the writable selection registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      notch <= '0;
      sel <= FILT_SEL_RESET;
    end else if (reg_wr_i && reg_addr_i == NOTCH_CFG_ADDR) begin
      notch <= {reg_wdata_i[9:8], 3'b000, reg_wdata_i[4:0]};
    end else if (reg_wr_i && reg_addr_i == FILT_SEL_ADDR) begin
      sel <= reg_wdata_i[15:0];
    end
  end
  // every stage off: the path must be transparent
  assign pass = notch[4:0] == CODE_OFF && sel[7:4] == LPF_INVALID && sel[11:8] == 4'h0;
  a_trq_latency: assert property (cmd_valid_i |-> ##3 trq_valid_o)
    else $error("sample output not three cycles after input");
  a_trq_origin: assert property (trq_valid_o |-> $past(cmd_valid_i, 3))
    else $error("sample output without an input");
  a_trq_hold: assert property (!trq_valid_o |-> $stable(trq_data_o))
    else $error("output sample changed between strobes");
  a_bypass_exact: assert property (trq_valid_o && pass && $past(pass, 4)
    |-> trq_data_o == $past(cmd_data_i, 3)) else $error("bypass path altered sample");
  a_rd_oneshot: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  a_notch_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == NOTCH_CFG_ADDR
    |-> reg_rdata_o == {22'h0, $past(notch)}) else $error("notch setting readback");
  a_sel_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == FILT_SEL_ADDR
    |-> reg_rdata_o == {16'h0, $past(sel)}) else $error("selection readback");
  a_invalid_clear: assert property ($past(reg_rd_i) && $past(reg_addr_i) == ADAPT_STATUS_ADDR
    && $past(sel[11:8], 2) == 4'h0 |-> reg_rdata_o == '0)
    else $error("adaptive notch present while invalid");
endmodule : rsf_filters_props

// *** sim/rsf_loop_model.sv ***
// speed loop model: torque samples and resonance estimates
`timescale 1ns/100ps
module rsf_loop_model
  import rsf_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // estimate and sample outputs
  output logic res_valid_o,
  output logic [CODE_W-1:0] res_code_o,
  output logic [LVL_W-1:0] res_level_o,
  output logic cmd_valid_o,
  output logic signed [15:0] cmd_data_o
);
  initial begin
    res_valid_o = 1'b0;
    res_code_o = '0;
    res_level_o = '0;
    cmd_valid_o = 1'b0;
    cmd_data_o = '0;
  end
  // one estimate strobe; fields scrambled once released
  task automatic send_res(input logic [4:0] c, input logic [15:0] l);
    @(posedge ref_clk_i);
    res_valid_o <= 1'b1;
    res_code_o <= c;
    res_level_o <= l;
    @(posedge ref_clk_i);
    res_valid_o <= 1'b0;
    res_code_o <= ~c;
    res_level_o <= ~l;
  endtask : send_res
  // back to back calls keep the strobe up
  task automatic send_cmd(input logic signed [15:0] d);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_data_o <= d;
  endtask : send_cmd
  task automatic idle;
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o <= ~cmd_data_o;
  endtask : idle
endmodule : rsf_loop_model

// *** sim/rsf_filters_tb.sv ***
// self-checking bench for the resonance suppression filters
`timescale 1ns/100ps
module rsf_filters_tb
  import rsf_pkg::*;
;
  logic ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, res_valid, cmd_valid, trq_valid_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic [CODE_W-1:0] res_code;
  logic [LVL_W-1:0] res_level;
  logic signed [15:0] cmd_data, trq_data_o;
  logic signed [15:0] got[$];
  int failures, checked;
  int pk[4];
  rsf_filters i_rsf_filters (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .res_valid_i(res_valid), .res_code_i(res_code),
    .res_level_i(res_level), .cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data),
    .trq_valid_o(trq_valid_o), .trq_data_o(trq_data_o));
  rsf_loop_model i_rsf_loop_model (.ref_clk_i(ref_clk_i), .res_valid_o(res_valid),
    .res_code_o(res_code), .res_level_o(res_level), .cmd_valid_o(cmd_valid),
    .cmd_data_o(cmd_data));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // collect filtered samples
  always @(posedge ref_clk_i) begin
    if (trq_valid_o === 1'b1) got.push_back(trq_data_o);
  end
  task automatic tally_and_finish;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 cmp(reg_rdata_o, e);
  endtask : rd
  task automatic rst;
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
  endtask : rst
  function automatic logic [31:0] st(input logic [4:0] c, input logic [1:0] d, input logic h);
    return {14'h0, h, 1'b1, 6'h0, d, 3'h0, c};
  endfunction : st
  task automatic t_reset_regs;
    rd(NOTCH_CFG_ADDR, 32'h0000_0000);
    rd(FILT_SEL_ADDR, 32'h0000_0000);
    rd(SPEED_GAIN2_ADDR, 32'h0000_0320);
    rd(INERTIA_RATIO_ADDR, 32'h0000_0046);
    rd(ADAPT_STATUS_ADDR, 32'h0000_0000);
    rd(LPF_ALPHA_ADDR, 32'h0000_065E);
    rd(8'h18, 32'h0000_0000);
  endtask : t_reset_regs
  task automatic t_alpha;
    wr(SPEED_GAIN2_ADDR, 32'h0000_0064);
    wr(INERTIA_RATIO_ADDR, 32'h0000_001E);
    rd(LPF_ALPHA_ADDR, 32'h0000_0197);
    wr(SPEED_GAIN2_ADDR, 32'h0000_FFFF);
    wr(INERTIA_RATIO_ADDR, 32'h0000_0000);
    rd(LPF_ALPHA_ADDR, 32'h0001_0000);
    wr(ADAPT_STATUS_ADDR, 32'hFFFF_FFFF);
    rd(ADAPT_STATUS_ADDR, 32'h0000_0000);
    wr(SPEED_GAIN2_ADDR, 32'h0000_0320);
    wr(INERTIA_RATIO_ADDR, 32'h0000_0046);
  endtask : t_alpha
  task automatic t_bypass;
    logic signed [15:0] v[5] = '{16'h7FFF, 16'h8000, 16'h1234, 16'h0000, 16'hFEDC};
    wr(FILT_SEL_ADDR, 32'h0000_0010);
    got.delete();
    foreach (v[i]) i_rsf_loop_model.send_cmd(v[i]);
    i_rsf_loop_model.idle();
    repeat (5) @(posedge ref_clk_i);
    cmp(got.size(), 5);
    foreach (v[i]) cmp(32'(got[i]), 32'(v[i]));
  endtask : t_bypass
  // a step must come out smoothed once the low-pass is back on
  task automatic t_lpf;
    wr(FILT_SEL_ADDR, 32'h0000_0000);
    got.delete();
    repeat (20) i_rsf_loop_model.send_cmd(16'sh4000);
    i_rsf_loop_model.idle();
    repeat (5) @(posedge ref_clk_i);
    cmp(32'(got[0] < 16'sh4000 && got[19] > got[0]), 1);
  endtask : t_lpf
  // 450 Hz tone; peak taken once the filters have settled
  task automatic tone(output int p);
    got.delete();
    for (int i = 0; i < 300; i++)
      i_rsf_loop_model.send_cmd(16'(int'(8000.0 * $sin(6.2832 * 450.0 * i / 40000.0))));
    i_rsf_loop_model.idle();
    repeat (5) @(posedge ref_clk_i);
    p = 0;
    for (int i = 150; i < got.size(); i++) if (got[i] > p) p = got[i];
  endtask : tone
  task automatic t_notch;
    for (int d = 0; d < 4; d++) begin
      wr(NOTCH_CFG_ADDR, {22'h0, 2'(d), 8'h0A});
      wr(FILT_SEL_ADDR, 32'h0000_0010);
      tone(pk[d]);
    end
    cmp(32'(pk[0] < pk[1] && pk[1] < pk[2] && pk[2] < pk[3]), 1);
    cmp(32'(pk[0] < 1200 && pk[3] < 7000), 1);
    wr(NOTCH_CFG_ADDR, 32'h0000_0000);
  endtask : t_notch
  task automatic t_adapt;
    wr(FILT_SEL_ADDR, 32'h0000_0110);
    i_rsf_loop_model.send_res(5'h0C, 16'h2000);
    rd(ADAPT_STATUS_ADDR, st(5'h0C, 2'd1, 1'b0));
    i_rsf_loop_model.send_res(5'h10, 16'h5000);
    rd(ADAPT_STATUS_ADDR, st(5'h10, 2'd0, 1'b0));
    i_rsf_loop_model.send_res(5'h08, 16'h5000);
    i_rsf_loop_model.send_res(5'h1F, 16'h5000);
    rd(ADAPT_STATUS_ADDR, st(5'h10, 2'd0, 1'b0));
    i_rsf_loop_model.send_res(5'h09, 16'h0400);
    rd(ADAPT_STATUS_ADDR, st(5'h09, 2'd2, 1'b0));
    i_rsf_loop_model.send_res(5'h1E, 16'h0100);
    rd(ADAPT_STATUS_ADDR, st(5'h09, 2'd2, 1'b0));
    wr(FILT_SEL_ADDR, 32'h0000_1110);
    i_rsf_loop_model.send_res(5'h1E, 16'h0100);
    rd(ADAPT_STATUS_ADDR, st(5'h1E, 2'd2, 1'b0));
    wr(FILT_SEL_ADDR, 32'h0000_0210);
    i_rsf_loop_model.send_res(5'h0C, 16'h5000);
    rd(ADAPT_STATUS_ADDR, st(5'h1E, 2'd2, 1'b1));
    wr(FILT_SEL_ADDR, 32'h0000_0010);
    rd(ADAPT_STATUS_ADDR, 32'h0000_0000);
  endtask : t_adapt
  // tuned notch must act on the stream; low-pass must keep negative halves
  task automatic t_adapt_tone;
    int p;
    wr(FILT_SEL_ADDR, 32'h0000_0110);
    i_rsf_loop_model.send_res(5'h0A, 16'h5000);
    tone(p);
    cmp(32'(p < 1200), 1);
    wr(FILT_SEL_ADDR, 32'h0000_0010);
    tone(p);
    cmp(32'(p > 7000), 1);
    wr(FILT_SEL_ADDR, 32'h0000_0000);
    tone(p);
    cmp(32'(p > 1000 && p < 7000), 1);
  endtask : t_adapt_tone
  initial begin
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    rst();
    t_reset_regs();
    t_alpha();
    t_bypass();
    t_lpf();
    t_notch();
    t_adapt();
    t_adapt_tone();
    rst();
    t_reset_regs();
    tally_and_finish();
  end
  // watchdog, well beyond the few thousand cycles expected
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule : rsf_filters_tb
bind rsf_filters rsf_filters_props i_rsf_filters_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .res_valid_i(res_valid_i), .res_code_i(res_code_i),
  .res_level_i(res_level_i), .cmd_valid_i(cmd_valid_i), .cmd_data_i(cmd_data_i),
  .trq_valid_o(trq_valid_o), .trq_data_o(trq_data_o));
